// File: logic/vic_pkg.sv
// constants and shared types of the vectored interrupt controller
// Operation
// - thirty-two vectors, each enabled on its own
// - per-vector priority, eight levels, runtime writable
// - up to eight nested levels, higher preempts
// - software write raises a vector's pending request
// - software write clears a pending request
// - per-vector handler address, no fixed table
// - request sets pending on next clock edge
// - posted set one step after pending
// - priority evaluation takes three clocks
// - address offered, acknowledge clears pending then posted
// - acknowledge indication cleared after seven cycles
// - completion restores previous active interrupt status
// - core finishes instruction, pushes pc, branches
// - return pops pc, resumes after interrupted instruction
// - equal priority: lower vector number wins
// - per-vector selector over three sources
// - two 16-bit dma terminal buses, low/high halves
// - 32-bit routing bus, bit n to vector n
// - fixed inputs; vectors 2, 26 have none
// - any source reaches any vector through routing
package vic_pkg;
  localparam int          NUM_VEC     = 32;
  localparam int          VEC_W       = 5;
  localparam int          PRIO_W      = 3;
  localparam int          APRIO_W     = 4;
  localparam int          NEST_MAX    = 8;
  localparam int          DEPTH_W     = 4;
  localparam int          HADDR_W     = 16;
  localparam int          DMA_W       = 16;
  localparam int          PADDR_W     = 12;
  localparam int          EVAL_CLKS   = 3;
  localparam int          ACK_CLKS    = 7;
  localparam int          CNT_W       = 3;
  localparam int          PRIO_PER_W  = 8;
  localparam int          SRC_PER_W   = 16;
  localparam logic [31:0] FIXED_MASK  = 32'hFBFF_FFFB;
  localparam logic [APRIO_W-1:0] PRIO_NONE = 4'h8;
  localparam logic [PADDR_W-1:0] OFF_ENABLE   = 12'h000;
  localparam logic [PADDR_W-1:0] OFF_SET_PENDING_FLAG = 12'h004;
  localparam logic [PADDR_W-1:0] OFF_CLR_PENDING_FLAG = 12'h008;
  localparam logic [PADDR_W-1:0] OFF_STATUS   = 12'h00C;
  localparam logic [PADDR_W-1:0] OFF_PRIO     = 12'h010;
  localparam logic [PADDR_W-1:0] OFF_SRC      = 12'h020;
  localparam logic [PADDR_W-1:0] OFF_ADDR     = 12'h080;
  localparam logic [31:0] ENABLE_RST  = 32'h0000_0000;
  localparam logic [31:0] PRIO_RST    = 32'h0000_0000;
  localparam logic [31:0] SRC_RST     = 32'h0000_0000;
  localparam logic [HADDR_W-1:0] ADDR_RST = 16'h0000;

  typedef enum logic [1:0] {
    VIC_SRC_FIXED = 2'b00,
    VIC_SRC_DMA   = 2'b01,
    VIC_SRC_ROUTE = 2'b10,
    VIC_SRC_OFF   = 2'b11
  } vic_src_t;

  typedef enum logic [1:0] {
    VIC_ST_IDLE = 2'b00,
    VIC_ST_EVAL = 2'b01,
    VIC_ST_REQ  = 2'b10,
    VIC_ST_ACK  = 2'b11
  } vic_state_t;
endpackage : vic_pkg

// File: logic/vic_if.sv
// link between the interrupt controller and the cpu core
interface vic_if;
  import vic_pkg::*;
  logic               irq_req;
  logic [VEC_W-1:0]   irq_vector;
  logic [HADDR_W-1:0] handler_addr;
  logic               ack_seen;
  logic               core_acknowledge;
  logic               handler_complete;

  modport ctrl (
    output irq_req,
    output irq_vector,
    output handler_addr,
    output ack_seen,
    input  core_acknowledge,
    input  handler_complete
  );

  modport core (
    input  irq_req,
    input  irq_vector,
    input  handler_addr,
    input  ack_seen,
    output core_acknowledge,
    output handler_complete
  );
endinterface : vic_if

// File: logic/vic_ctrl.sv
// interrupt controller end: apb registers, capture, arbitration, nesting
module vic_ctrl (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [vic_pkg::PADDR_W-1:0]     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [vic_pkg::NUM_VEC-1:0]     fixed_irq,
  input  wire logic [vic_pkg::DMA_W-1:0]       dma_terminal_out_low,
  input  wire logic [vic_pkg::DMA_W-1:0]       dma_terminal_out_high,
  input  wire logic [vic_pkg::NUM_VEC-1:0]     route_irq,
  vic_if.ctrl                                  link
);
  import vic_pkg::*;

  logic [NUM_VEC-1:0] enable_reg;
  logic [NUM_VEC-1:0] pending_flag;
  logic [NUM_VEC-1:0] posted_flag;
  logic [NUM_VEC-1:0] src_q_reg;
  logic [NUM_VEC-1:0] posted_flag_clr_reg;
  logic [PRIO_W-1:0]  prio_reg [NUM_VEC];
  vic_src_t           src_reg  [NUM_VEC];
  logic [HADDR_W-1:0] addr_mem [NUM_VEC];
  logic [31:0]        prdata_reg;
  logic               rd_err_reg;
  vic_state_t         state_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic [VEC_W-1:0]   win_vec_reg;
  logic [APRIO_W-1:0] win_prio_reg;
  logic [HADDR_W-1:0] haddr_reg;
  logic [APRIO_W-1:0] act_prio_reg;
  logic [VEC_W-1:0]   act_vec_reg;
  logic [DEPTH_W-1:0] depth_reg;
  logic [APRIO_W-1:0] stk_prio [NEST_MAX];
  logic [VEC_W-1:0]   stk_vec  [NEST_MAX];

  logic               wr_en;
  logic               setup;
  logic [NUM_VEC-1:0] sel_src;
  logic [NUM_VEC-1:0] hw_set;
  logic [NUM_VEC-1:0] sw_set;
  logic [NUM_VEC-1:0] sw_clr;
  logic [NUM_VEC-1:0] ack_clr;
  logic               cand;
  logic [VEC_W-1:0]   best_vec;
  logic [APRIO_W-1:0] best_prio;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic               ack;
  logic               done;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = psel & penable & rd_err_reg;

  // source selection per vector
  always_comb begin
    for (int v = 0; v < NUM_VEC; v++) begin
      unique case (src_reg[v])
        VIC_SRC_FIXED: sel_src[v] = fixed_irq[v] & FIXED_MASK[v];
        VIC_SRC_DMA:   sel_src[v] = (v < DMA_W) ? dma_terminal_out_low[v % DMA_W]
                                               : dma_terminal_out_high[v % DMA_W];
        VIC_SRC_ROUTE: sel_src[v] = route_irq[v];
        VIC_SRC_OFF:   sel_src[v] = 1'b0;
      endcase
    end
  end

  // edge capture so a level held through the handler does not re-fire
  assign hw_set = sel_src & ~src_q_reg;
  assign sw_set = (wr_en && paddr == OFF_SET_PENDING_FLAG) ? pwdata : '0;
  assign sw_clr = (wr_en && paddr == OFF_CLR_PENDING_FLAG) ? pwdata : '0;
  assign ack    = (state_reg == VIC_ST_REQ) & link.core_acknowledge;
  assign done   = link.handler_complete & (depth_reg != '0);
  assign ack_clr = ack ? (NUM_VEC'(1) << win_vec_reg) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q_reg <= '0;
    end else begin
      src_q_reg <= sel_src;
    end
  end

  // a new request in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_flag <= '0;
    end else begin
      pending_flag <= (pending_flag & ~sw_clr & ~ack_clr) | hw_set | sw_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      posted_flag  <= '0;
      posted_flag_clr_reg <= '0;
    end else begin
      posted_flag_clr_reg <= ack_clr;
      posted_flag  <= (posted_flag & ~posted_flag_clr_reg & ~sw_clr) | (pending_flag & ~sw_clr & enable_reg);
    end
  end

  // priority search, 0 is most urgent; descending walk with <= keeps the lower number
  always_comb begin
    best_prio = PRIO_NONE;
    best_vec  = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (posted_flag[v] && {1'b0, prio_reg[v]} <= best_prio) begin
        best_prio = {1'b0, prio_reg[v]};
        best_vec  = VEC_W'(v);
      end
    end
  end

  // only a strictly more urgent level may preempt the running handler
  assign cand = (best_prio < act_prio_reg) && (depth_reg < DEPTH_W'(NEST_MAX));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= VIC_ST_IDLE;
      cnt_reg      <= '0;
      win_vec_reg  <= '0;
      win_prio_reg <= PRIO_NONE;
      haddr_reg    <= '0;
    end else begin
      unique case (state_reg)
        VIC_ST_IDLE: begin
          if (cand) begin
            state_reg <= VIC_ST_EVAL;
            cnt_reg   <= CNT_W'(1);
          end
        end
        VIC_ST_EVAL: begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(EVAL_CLKS - 1)) begin
            state_reg    <= cand ? VIC_ST_REQ : VIC_ST_IDLE;
            win_vec_reg  <= best_vec;
            win_prio_reg <= best_prio;
            haddr_reg    <= addr_mem[best_vec];
          end
        end
        VIC_ST_REQ: begin
          if (ack) begin
            state_reg <= VIC_ST_ACK;
            cnt_reg   <= CNT_W'(1);
          end
        end
        VIC_ST_ACK: begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(ACK_CLKS)) begin
            state_reg <= VIC_ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.irq_req      = (state_reg == VIC_ST_REQ);
  assign link.irq_vector   = win_vec_reg;
  assign link.handler_addr = haddr_reg;
  assign link.ack_seen     = (state_reg == VIC_ST_ACK);

  // nesting stack of the interrupted handlers' status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_reg    <= '0;
      act_prio_reg <= PRIO_NONE;
      act_vec_reg  <= '0;
      for (int i = 0; i < NEST_MAX; i++) begin
        stk_prio[i] <= PRIO_NONE;
        stk_vec[i]  <= '0;
      end
    end else if (ack) begin
      stk_prio[depth_reg[2:0]] <= act_prio_reg;
      stk_vec[depth_reg[2:0]]  <= act_vec_reg;
      depth_reg    <= depth_reg + DEPTH_W'(1);
      act_prio_reg <= win_prio_reg;
      act_vec_reg  <= win_vec_reg;
    end else if (done) begin
      depth_reg    <= depth_reg - DEPTH_W'(1);
      act_prio_reg <= stk_prio[3'(depth_reg - DEPTH_W'(1))];
      act_vec_reg  <= stk_vec[3'(depth_reg - DEPTH_W'(1))];
    end
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= ENABLE_RST;
      for (int v = 0; v < NUM_VEC; v++) begin
        prio_reg[v] <= PRIO_RST[PRIO_W-1:0];
        src_reg[v]  <= vic_src_t'(SRC_RST[1:0]);
        addr_mem[v] <= ADDR_RST;
      end
    end else if (wr_en) begin
      if (paddr == OFF_ENABLE) begin
        enable_reg <= pwdata;
      end
      for (int v = 0; v < NUM_VEC; v++) begin
        if (paddr == OFF_PRIO + PADDR_W'((v / PRIO_PER_W) * 4)) begin
          prio_reg[v] <= pwdata[(v % PRIO_PER_W) * 4 +: PRIO_W];
        end
        if (paddr == OFF_SRC + PADDR_W'((v / SRC_PER_W) * 4)) begin
          src_reg[v] <= vic_src_t'(pwdata[(v % SRC_PER_W) * 2 +: 2]);
        end
        if (paddr == OFF_ADDR + PADDR_W'(v * 4)) begin
          addr_mem[v] <= pwdata[HADDR_W-1:0];
        end
      end
    end
  end

  // read decode; unmapped words read zero with an error
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b0;
    if (paddr == OFF_ENABLE) begin
      rd_data = enable_reg;
      rd_ok   = 1'b1;
    end else if (paddr == OFF_SET_PENDING_FLAG) begin
      rd_data = pending_flag;
      rd_ok   = 1'b1;
    end else if (paddr == OFF_CLR_PENDING_FLAG) begin
      rd_data = posted_flag;
      rd_ok   = 1'b1;
    end else if (paddr == OFF_STATUS) begin
      rd_data = {12'h000, state_reg, depth_reg, act_prio_reg, win_vec_reg, act_vec_reg};
      rd_ok   = 1'b1;
    end
    for (int v = 0; v < NUM_VEC; v++) begin
      if (paddr == OFF_PRIO + PADDR_W'((v / PRIO_PER_W) * 4)) begin
        rd_data[(v % PRIO_PER_W) * 4 +: PRIO_W] = prio_reg[v];
        rd_ok = 1'b1;
      end
      if (paddr == OFF_SRC + PADDR_W'((v / SRC_PER_W) * 4)) begin
        rd_data[(v % SRC_PER_W) * 2 +: 2] = src_reg[v];
        rd_ok = 1'b1;
      end
      if (paddr == OFF_ADDR + PADDR_W'(v * 4)) begin
        rd_data[HADDR_W-1:0] = addr_mem[v];
        rd_ok = 1'b1;
      end
    end
  end

  // read data latched in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      rd_err_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
      rd_err_reg <= ~rd_ok;
    end
  end
endmodule : vic_ctrl

// File: logic/vic_core.sv
// cpu core end: acknowledges, stacks the return pc, signals completion
module vic_core #(
  parameter int NEST = vic_pkg::NEST_MAX
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  vic_if.core                                link,
  input  wire logic                          instr_done,
  input  wire logic [vic_pkg::HADDR_W-1:0]   next_pc,
  input  wire logic                          return_from_interrupt_op,
  output logic                               branch_valid,
  output logic      [vic_pkg::HADDR_W-1:0]   branch_pc,
  output logic      [vic_pkg::VEC_W-1:0]     branch_vector,
  output logic                               resume_valid,
  output logic      [vic_pkg::HADDR_W-1:0]   resume_pc,
  output logic      [vic_pkg::DEPTH_W-1:0]   nest_depth
);
  import vic_pkg::*;

  logic [HADDR_W-1:0] pc_stack [NEST];
  logic [DEPTH_W-1:0] depth_reg;
  logic               branch_valid_reg;
  logic [HADDR_W-1:0] branch_pc_reg;
  logic [VEC_W-1:0]   branch_vec_reg;
  logic               resume_valid_reg;
  logic [HADDR_W-1:0] resume_pc_reg;
  logic               ack;
  logic               ret;

  // take only at an instruction boundary; a return in the same cycle defers the take
  assign ack = link.irq_req & instr_done & ~return_from_interrupt_op
             & (depth_reg < DEPTH_W'(NEST));
  assign ret = return_from_interrupt_op & (depth_reg != '0);
  assign link.core_acknowledge = ack;
  assign link.handler_complete = ret;

  assign branch_valid  = branch_valid_reg;
  assign branch_pc     = branch_pc_reg;
  assign branch_vector = branch_vec_reg;
  assign resume_valid  = resume_valid_reg;
  assign resume_pc     = resume_pc_reg;
  assign nest_depth    = depth_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_reg <= '0;
      for (int i = 0; i < NEST; i++) begin
        pc_stack[i] <= '0;
      end
    end else if (ack) begin
      pc_stack[3'(depth_reg)] <= next_pc;
      depth_reg <= depth_reg + DEPTH_W'(1);
    end else if (ret) begin
      depth_reg <= depth_reg - DEPTH_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_valid_reg <= 1'b0;
      branch_pc_reg    <= '0;
      branch_vec_reg   <= '0;
    end else begin
      branch_valid_reg <= ack;
      if (ack) begin
        branch_pc_reg  <= link.handler_addr;
        branch_vec_reg <= link.irq_vector;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_valid_reg <= 1'b0;
      resume_pc_reg    <= '0;
    end else begin
      resume_valid_reg <= ret;
      if (ret) begin
        resume_pc_reg <= pc_stack[3'(depth_reg - DEPTH_W'(1))];
      end
    end
  end
endmodule : vic_core

// File: verification/vic_sva.sv
// assertion checker watching the controller-to-core link
module vic_sva (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        irq_req,
  input wire logic [vic_pkg::VEC_W-1:0]   irq_vector,
  input wire logic [vic_pkg::HADDR_W-1:0] handler_addr,
  input wire logic                        ack_seen,
  input wire logic                        core_acknowledge,
  input wire logic                        handler_complete
);
  import vic_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_ACK_SEVEN: assert property (core_acknowledge |=> ack_seen [*7] ##1 !ack_seen)
    else $error("ack indication length wrong");
  AST_ACK_DROPS_REQ: assert property (core_acknowledge |=> !irq_req)
    else $error("request still up after ack");
  AST_ACK_ON_REQ: assert property (core_acknowledge |-> irq_req)
    else $error("ack without request");
  AST_ACK_PULSE: assert property (core_acknowledge |=> !core_acknowledge)
    else $error("ack longer than one cycle");
  // request, vector and address must not wander while the core is busy
  AST_REQ_HOLDS: assert property (irq_req && !core_acknowledge |=>
    irq_req && $stable(irq_vector) && $stable(handler_addr))
    else $error("request dropped or changed before ack");
  AST_NO_REQ_IN_ACK: assert property (ack_seen |-> !irq_req)
    else $error("request during ack window");
  AST_ACK_SEEN_CAUSE: assert property ($rose(ack_seen) |-> $past(core_acknowledge))
    else $error("ack indication without ack");
  AST_ACK_NOT_COMPLETE: assert property (!(core_acknowledge && handler_complete))
    else $error("ack and completion together");
  // evaluation needs three clocks, so no request right after idle
  AST_EVAL_GAP: assert property ($fell(ack_seen) |-> !irq_req ##1 !irq_req)
    else $error("request too soon after ack window");

  COV_ACK: cover property (core_acknowledge);
  COV_DONE: cover property (handler_complete);
  COV_WINDOW_END: cover property ($fell(ack_seen));
endmodule : vic_sva

// File: verification/tb_top.sv
// self-checking bench for controller and core ends joined by the link
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;

  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [PADDR_W-1:0]   paddr;
  logic [31:0]          pwdata, prdata, rd, en_sh;
  logic [31:0]          prio_sh [4];
  logic [31:0]          src_sh [2];
  logic [NUM_VEC-1:0]   fixed_irq, route_irq;
  logic [DMA_W-1:0]     dma_terminal_out_low, dma_terminal_out_high;
  logic                 instr_done, return_from_interrupt_op, branch_valid, resume_valid;
  logic [HADDR_W-1:0]   next_pc, branch_pc, resume_pc;
  logic [VEC_W-1:0]     branch_vector;
  logic [DEPTH_W-1:0]   nest_depth;
  int                   err_count, n_compared;

  vic_if u_vic_if ();
  vic_ctrl u_vic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fixed_irq(fixed_irq), .dma_terminal_out_low(dma_terminal_out_low),
    .dma_terminal_out_high(dma_terminal_out_high), .route_irq(route_irq), .link(u_vic_if));
  vic_core #(.NEST(NEST_MAX)) u_vic_core (.pclk(pclk), .presetn(presetn), .link(u_vic_if),
    .instr_done(instr_done), .next_pc(next_pc), .return_from_interrupt_op(return_from_interrupt_op),
    .branch_valid(branch_valid), .branch_pc(branch_pc), .branch_vector(branch_vector),
    .resume_valid(resume_valid), .resume_pc(resume_pc), .nest_depth(nest_depth));
  vic_sva u_vic_sva (.pclk(pclk), .presetn(presetn), .irq_req(u_vic_if.irq_req),
    .irq_vector(u_vic_if.irq_vector), .handler_addr(u_vic_if.handler_addr), .ack_seen(u_vic_if.ack_seen),
    .core_acknowledge(u_vic_if.core_acknowledge), .handler_complete(u_vic_if.handler_complete));

  always #2.5 pclk = ~pclk;

  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb master; waits on pready, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // shadows keep the other vectors' fields intact on word writes
  task automatic cfg(input int v, input logic [1:0] s, input logic [2:0] p, input logic [15:0] a);
    src_sh[v/16][2*(v%16)+:2] = s;
    prio_sh[v/8][4*(v%8)+:3] = p;
    en_sh[v] = 1'b1;
    apb(1'b1, OFF_SRC + 12'(4*(v/16)), src_sh[v/16]);
    apb(1'b1, OFF_PRIO + 12'(4*(v/8)), prio_sh[v/8]);
    apb(1'b1, OFF_ADDR + 12'(4*v), {16'h0000, a});
    apb(1'b1, OFF_ENABLE, en_sh);
  endtask : cfg

  task automatic raise(input logic [1:0] s, input logic [31:0] m);
    @(posedge pclk);
    if (s == VIC_SRC_FIXED) fixed_irq <= m;
    else if (s == VIC_SRC_DMA) {dma_terminal_out_high, dma_terminal_out_low} <= m;
    else route_irq <= m;
    repeat (2) @(posedge pclk);
    fixed_irq <= '0;
    route_irq <= '0;
    dma_terminal_out_low <= '0;
    dma_terminal_out_high <= '0;
  endtask : raise

  // looks from the next edge on, so a pulse already seen is not counted twice
  task automatic wait_hi(ref logic f, output logic seen);
    seen = 1'b0;
    for (int n = 0; n < 30 && !seen; n++) begin
      @(posedge pclk);
      #1;
      seen = (f === 1'b1);
    end
  endtask : wait_hi

  task automatic take(input int v, input logic [15:0] a, input logic exp);
    logic seen;
    wait_hi(branch_valid, seen);
    chk(seen, exp);
    if (seen && exp) begin
      chk(branch_vector, v);
      chk(branch_pc, a);
    end
  endtask : take

  // resume pulse stands only in the cycle after the return edge
  task automatic ret(input logic [15:0] pc);
    @(posedge pclk);
    return_from_interrupt_op <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_op <= 1'b0;
    #1;
    chk(resume_valid, 1'b1);
    chk(resume_pc, pc);
  endtask : ret

  task automatic t_reset();
    apb(1'b0, OFF_ENABLE, 32'h0);
    chk(rd, ENABLE_RST);
    apb(1'b0, OFF_PRIO, 32'h0);
    chk(rd, PRIO_RST);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_2000);
    apb(1'b0, 12'h040, 32'h0);
    chk({rd[30:0], err}, 32'h0000_0001);
  endtask : t_reset

  task automatic t_basic();
    cfg(5, VIC_SRC_ROUTE, 3'h3, 16'h1234);
    next_pc <= 16'h0100;
    instr_done <= 1'b0;
    raise(VIC_SRC_ROUTE, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    #1 chk(u_vic_if.irq_req, 1'h0);
    repeat (2) @(posedge pclk);
    #1 chk(u_vic_if.irq_req, 1'h1);
    chk({u_vic_if.irq_vector, u_vic_if.handler_addr}, {5'h05, 16'h1234});
    apb(1'b0, OFF_SET_PENDING_FLAG, 32'h0);
    chk(rd[5], 1'h1);
    apb(1'b0, OFF_CLR_PENDING_FLAG, 32'h0);
    chk(rd[5], 1'h1);
    instr_done <= 1'b1;
    take(5, 16'h1234, 1'b1);
    apb(1'b0, OFF_SET_PENDING_FLAG, 32'h0);
    chk(rd[5], 1'h0);
    apb(1'b0, OFF_CLR_PENDING_FLAG, 32'h0);
    chk({rd[5], nest_depth}, 5'h01);
    ret(16'h0100);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({rd[17:10], nest_depth}, 12'h080);
  endtask : t_basic

  task automatic t_tie();
    cfg(7, VIC_SRC_ROUTE, 3'h4, 16'h0700);
    cfg(3, VIC_SRC_ROUTE, 3'h4, 16'h0300);
    next_pc <= 16'h0A00;
    raise(VIC_SRC_ROUTE, 32'h0000_0088);
    take(3, 16'h0300, 1'b1);
    take(7, 16'h0700, 1'b0);
    chk(nest_depth, 4'h1);
    ret(16'h0A00);
    take(7, 16'h0700, 1'b1);
    ret(16'h0A00);
  endtask : t_tie

  task automatic t_nest();
    cfg(10, VIC_SRC_ROUTE, 3'h5, 16'h1000);
    next_pc <= 16'h0200;
    raise(VIC_SRC_ROUTE, 32'h0000_0400);
    take(10, 16'h1000, 1'b1);
    cfg(12, VIC_SRC_ROUTE, 3'h1, 16'h1200);
    next_pc <= 16'h0300;
    apb(1'b1, OFF_SET_PENDING_FLAG, 32'h0000_1000);
    take(12, 16'h1200, 1'b1);
    chk(nest_depth, 4'h2);
    ret(16'h0300);
    ret(16'h0200);
    chk(nest_depth, 4'h0);
  endtask : t_nest

  task automatic t_swclr();
    cfg(9, VIC_SRC_ROUTE, 3'h0, 16'h0900);
    en_sh[9] = 1'b0;
    apb(1'b1, OFF_ENABLE, en_sh);
    apb(1'b1, OFF_SET_PENDING_FLAG, 32'h0000_0200);
    take(9, 16'h0900, 1'b0);
    apb(1'b0, OFF_SET_PENDING_FLAG, 32'h0);
    chk(rd[9], 1'h1);
    apb(1'b1, OFF_CLR_PENDING_FLAG, 32'h0000_0200);
    apb(1'b0, OFF_SET_PENDING_FLAG, 32'h0);
    chk(rd[9], 1'h0);
    en_sh[9] = 1'b1;
    apb(1'b1, OFF_ENABLE, en_sh);
    instr_done <= 1'b0;
    apb(1'b1, OFF_SET_PENDING_FLAG, 32'h0000_0200);
    apb(1'b1, OFF_CLR_PENDING_FLAG, 32'h0000_0200);
    apb(1'b0, OFF_CLR_PENDING_FLAG, 32'h0);
    chk(rd[9], 1'h0);
    instr_done <= 1'b1;
    take(9, 16'h0900, 1'b0);
  endtask : t_swclr

  // fixed and dma inputs per vector; 2 and 26 have no fixed line
  task automatic t_src();
    int          vt [5] = '{4, 20, 13, 2, 26};
    logic [1:0]  st [5] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
    logic        xt [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      cfg(vt[i], st[i], 3'h2, 16'h4000 + 16'(vt[i]));
      raise(st[i], 32'h1 << vt[i]);
      take(vt[i], 16'h4000 + 16'(vt[i]), xt[i]);
      if (xt[i]) ret(next_pc);
    end
  endtask : t_src

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fixed_irq, route_irq, dma_terminal_out_low, dma_terminal_out_high} = '0;
    {return_from_interrupt_op, next_pc, en_sh} = '0;
    instr_done = 1'b1;
    prio_sh = '{default: 32'h0};
    src_sh = '{default: 32'h0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_basic();
    t_tie();
    t_nest();
    t_swclr();
    t_src();
    summarize();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule : tb_top
